/* design/timer16_byte_access.sv */
`include "timer16_map.svh"
`default_nettype none
module timer16_byte_access #(
	parameter int WIDTH = 16
) (
	input  wire logic                 mclk_i,      // System clock, 250 MHz
	input  wire logic                 rst_n_i,     // Synchronous reset, active low
	input  wire timer16_pkg::cpu_req_t req_i,      // Byte access request
	output logic [7:0]                rdata_o,     // Read data, registered
	input  wire logic                 ext_clk_i,   // External count source
	input  wire logic                 capture_i,   // Capture strobe, one cycle
	input  wire logic                 clear_i,     // Counter clear request
	input  wire logic                 down_i,      // Mode asks for downward count
	output logic [WIDTH-1:0]          counter_value_o, // Counter value
	output logic [WIDTH-1:0]          compare_a_o, // Compare value A
	output logic [WIDTH-1:0]          compare_b_o, // Compare value B
	output logic [WIDTH-1:0]          capture_value_o, // Capture value
	output logic [7:0]                timer_control_b_o // Control register B
);

	initial begin
		if (WIDTH != 16) $error("Byte pairing serves exactly 16-bit registers");
	end

	////////////////////////////////////////////////////////////////////////////
	// Decode

	function automatic logic hit(input timer16_pkg::cpu_req_t r, input logic [3:0] a);
		return r.addr == a;
	endfunction

	logic [7:0]       hold_r;
	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] cmpa_r;
	logic [WIDTH-1:0] cmpb_r;
	logic [WIDTH-1:0] cap_r;
	logic [7:0]       ctlb_r;
	logic             tick;
	logic [7:0]       rd_nxt;
	timer16_pkg::count_dir_t dir;

	logic wr_cnt_lo, wr_cmpa_lo, wr_cmpb_lo, wr_cap_lo;
	logic wr_hold, rd_cnt_lo, rd_cap_lo;
	logic [WIDTH-1:0] commit;

	assign commit     = {hold_r, req_i.wdata};
	assign wr_cnt_lo  = req_i.wr & hit(req_i, `T16_ADDR_CNT_LO);
	assign wr_cmpa_lo = req_i.wr & hit(req_i, `T16_ADDR_CMPA_LO);
	assign wr_cmpb_lo = req_i.wr & hit(req_i, `T16_ADDR_CMPB_LO);
	assign wr_cap_lo  = req_i.wr & hit(req_i, `T16_ADDR_CAP_LO);
	// All four high-byte locations land in the single holding register
	assign wr_hold    = req_i.wr & (hit(req_i, `T16_ADDR_CNT_HI) | hit(req_i, `T16_ADDR_CMPA_HI)
		| hit(req_i, `T16_ADDR_CMPB_HI) | hit(req_i, `T16_ADDR_CAP_HI));
	assign rd_cnt_lo  = req_i.rd & hit(req_i, `T16_ADDR_CNT_LO);
	assign rd_cap_lo  = req_i.rd & hit(req_i, `T16_ADDR_CAP_LO);

	////////////////////////////////////////////////////////////////////////////
	// Holding register

	// Compare low reads leave it alone, so a compare read pair never disturbs it
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) hold_r <= `T16_HOLD_RST;
		else if (wr_hold) hold_r <= req_i.wdata;
		else if (rd_cnt_lo) hold_r <= cnt_r[15:8];
		else if (rd_cap_lo) hold_r <= cap_r[15:8];
		// Otherwise the value stays for reuse by later low-byte writes
	end

	////////////////////////////////////////////////////////////////////////////
	// Wide registers and control register B

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) cmpa_r <= `T16_WIDE_RST;
		else if (wr_cmpa_lo) cmpa_r <= commit;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) cmpb_r <= `T16_WIDE_RST;
		else if (wr_cmpb_lo) cmpb_r <= commit;
	end

	// Software write wins over a hardware capture in the same cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) cap_r <= `T16_WIDE_RST;
		else if (wr_cap_lo) cap_r <= commit;
		else if (capture_i) cap_r <= cnt_r;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) ctlb_r <= `T16_CTLB_RST;
		else if (req_i.wr && hit(req_i, `T16_ADDR_CTLB)) ctlb_r <= req_i.wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter core

	timer16_tick_sel #(
		.DIV_W (10)
	) u_tick (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.cs_i    (ctlb_r[`T16_CS_LSB +: `T16_CS_W]),
		.ext_i   (ext_clk_i),
		.tick_o  (tick)
	);

	always_comb begin
		if (!tick) dir = timer16_pkg::DIR_IDLE;
		else if (down_i | ctlb_r[`T16_DIR_BIT]) dir = timer16_pkg::DIR_DOWN;
		else dir = timer16_pkg::DIR_UP;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) cnt_r <= `T16_WIDE_RST;
		else if (wr_cnt_lo) cnt_r <= commit;
		else if (clear_i && tick) cnt_r <= `T16_WIDE_RST;
		else begin
			case (dir)
			timer16_pkg::DIR_UP:   cnt_r <= cnt_r + 16'h0001;
			timer16_pkg::DIR_DOWN: cnt_r <= cnt_r - 16'h0001;
			timer16_pkg::DIR_IDLE: cnt_r <= cnt_r;
			default:               cnt_r <= cnt_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path, one byte per access

	always_comb begin
		rd_nxt = 8'h00;
		case (req_i.addr)
		`T16_ADDR_CNT_LO:  rd_nxt = cnt_r[7:0];
		`T16_ADDR_CNT_HI:  rd_nxt = hold_r;
		`T16_ADDR_CMPA_LO: rd_nxt = cmpa_r[7:0];
		`T16_ADDR_CMPA_HI: rd_nxt = cmpa_r[15:8];
		`T16_ADDR_CMPB_LO: rd_nxt = cmpb_r[7:0];
		`T16_ADDR_CMPB_HI: rd_nxt = cmpb_r[15:8];
		`T16_ADDR_CAP_LO:  rd_nxt = cap_r[7:0];
		`T16_ADDR_CAP_HI:  rd_nxt = hold_r;
		`T16_ADDR_CTLB:    rd_nxt = ctlb_r;
		default:           rd_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) rdata_o <= 8'h00;
		else if (req_i.rd) rdata_o <= rd_nxt;
	end

	assign counter_value_o   = cnt_r;
	assign compare_a_o       = cmpa_r;
	assign compare_b_o       = cmpb_r;
	assign capture_value_o   = cap_r;
	assign timer_control_b_o = ctlb_r;

endmodule
`default_nettype wire

/* design/timer16_map.svh */
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH

// Byte locations of the wide registers and control register B on the 8-bit access port
`define T16_ADDR_CNT_LO  4'h0
`define T16_ADDR_CNT_HI  4'h1
`define T16_ADDR_CMPA_LO 4'h2
`define T16_ADDR_CMPA_HI 4'h3
`define T16_ADDR_CMPB_LO 4'h4
`define T16_ADDR_CMPB_HI 4'h5
`define T16_ADDR_CAP_LO  4'h6
`define T16_ADDR_CAP_HI  4'h7
`define T16_ADDR_CTLB    4'h8

// Control register B fields
`define T16_CS_LSB       0
`define T16_CS_W         3
`define T16_DIR_BIT      3

// Reset values
`define T16_HOLD_RST     8'h00
`define T16_WIDE_RST     16'h0000
`define T16_CTLB_RST     8'h00

// Clock select codes
`define T16_CS_STOP      3'h0
`define T16_CS_SYS       3'h1
`define T16_CS_DIV8      3'h2
`define T16_CS_DIV64     3'h3
`define T16_CS_DIV256    3'h4
`define T16_CS_DIV1024   3'h5
`define T16_CS_EXT_FALL  3'h6
`define T16_CS_EXT_RISE  3'h7

`endif

/* design/timer16_pkg.sv */
`default_nettype none
package timer16_pkg;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} cpu_req_t;

	typedef enum logic [2:0] {
		DIR_IDLE = 3'b001,
		DIR_UP   = 3'b010,
		DIR_DOWN = 3'b100
	} count_dir_t;

endpackage
`default_nettype wire

/* design/timer16_tick_sel.sv */
`include "timer16_map.svh"
`default_nettype none
module timer16_tick_sel #(
	parameter int DIV_W = 10
) (
	input  wire logic       mclk_i,   // System clock
	input  wire logic       rst_n_i,  // Synchronous reset, active low
	input  wire logic [2:0] cs_i,     // Clock select field
	input  wire logic       ext_i,    // External count pin
	output logic            tick_o    // One-cycle count enable
);

	initial begin
		if (DIV_W < 10) $error("DIV_W must cover the divide-by-1024 tap");
	end

	logic [DIV_W-1:0] div_r;
	logic             ext_r;

	// Free-running divider; every tap is a one-cycle enable, no derived clocks
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) div_r <= '0;
		else div_r <= div_r + 1'b1;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) ext_r <= 1'b0;
		else ext_r <= ext_i;
	end

	always_comb begin
		case (cs_i)
		`T16_CS_STOP:      tick_o = 1'b0;
		`T16_CS_SYS:       tick_o = 1'b1;
		`T16_CS_DIV8:      tick_o = (div_r[2:0] == 3'h7);
		`T16_CS_DIV64:     tick_o = (div_r[5:0] == 6'h3f);
		`T16_CS_DIV256:    tick_o = (div_r[7:0] == 8'hff);
		`T16_CS_DIV1024:   tick_o = (div_r[9:0] == 10'h3ff);
		`T16_CS_EXT_FALL:  tick_o = ext_r & ~ext_i;
		`T16_CS_EXT_RISE:  tick_o = ~ext_r & ext_i;
		default:           tick_o = 1'b0;
		endcase
	end

endmodule
`default_nettype wire

/* sim/timer16_byte_access_props.sv */
`default_nettype none
module timer16_byte_access_props #(
	parameter int WIDTH = 16
) (
	input wire logic                  mclk_i,
	input wire logic                  rst_n_i,
	input wire timer16_pkg::cpu_req_t req_i,
	input wire logic [7:0]            rdata_o,
	input wire logic                  down_i,
	input wire logic                  clear_i,
	input wire logic [WIDTH-1:0]      counter_value_o,
	input wire logic [WIDTH-1:0]      compare_a_o,
	input wire logic [WIDTH-1:0]      capture_value_o,
	input wire logic [7:0]            timer_control_b_o
);
	logic [7:0] hold_r;
	wire logic  wr0 = req_i.wr && req_i.addr == 4'h0;
	wire logic  dn  = down_i || timer_control_b_o[3];
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////////
	// Shadow of the shared high byte, so commits and reads can be predicted
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i)
			hold_r <= 8'h00;
		else if (req_i.wr && req_i.addr[0] && !req_i.addr[3])
			hold_r <= req_i.wdata;
		else if (req_i.rd && req_i.addr == 4'h0)
			hold_r <= counter_value_o[15:8];
		else if (req_i.rd && req_i.addr == 4'h6)
			hold_r <= capture_value_o[15:8];
	end
	////////////////////////////////////////////////////////////////////////
	cnt_commit_a: assert property (
		wr0 |=> counter_value_o == {$past(hold_r), $past(req_i.wdata)}) else $error("bad commit");
	lo_read_a: assert property (
		req_i.rd && req_i.addr == 4'h0 |=> rdata_o == $past(counter_value_o[7:0]))
		else $error("bad low read");
	hold_read_a: assert property (
		req_i.rd && (req_i.addr == 4'h1 || req_i.addr == 4'h7) |=> rdata_o == $past(hold_r))
		else $error("bad hold read");
	cmp_hi_read_a: assert property (
		req_i.rd && req_i.addr == 4'h3 |=> rdata_o == $past(compare_a_o[15:8]))
		else $error("bad compare read");
	rdata_keep_a: assert property (
		!req_i.rd |=> $stable(rdata_o)) else $error("read data moved");
	stop_keep_a: assert property (
		(timer_control_b_o[2:0] == 3'h0 && !wr0) [*3] |=> $stable(counter_value_o))
		else $error("stopped counter moved");
	count_step_a: assert property (
		(timer_control_b_o[2:0] == 3'h1 && !clear_i && !wr0 && dn == $past(dn)) [*3] |=>
		counter_value_o == $past(counter_value_o) + ($past(dn) ? 16'hffff : 16'h0001))
		else $error("bad count step");
	clear_zero_a: assert property (
		(timer_control_b_o[2:0] == 3'h1 && clear_i && !wr0) [*3] |=> counter_value_o == 16'h0000)
		else $error("clear missed");
endmodule
bind timer16_byte_access timer16_byte_access_props #(.WIDTH(WIDTH)) props (.mclk_i(mclk_i),
	.rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o), .down_i(down_i), .clear_i(clear_i),
	.counter_value_o(counter_value_o), .compare_a_o(compare_a_o),
	.capture_value_o(capture_value_o), .timer_control_b_o(timer_control_b_o));
`default_nettype wire

/* sim/timer16_cpu_model.sv */
`default_nettype none
module timer16_cpu_model (
	input wire logic                   mclk_i,  // System clock
	output var timer16_pkg::cpu_req_t  req_o,   // Byte request
	input wire logic [7:0]             rdata_i  // Read byte
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req_o = '0;
	// One byte per call; the request stays up so calls can run back to back
	task automatic xfer(input logic rd, input logic [3:0] a, input logic [7:0] wd,
		output logic [7:0] q);
		req_o = '{rd: rd, wr: !rd, addr: a, wdata: wd};
		@(posedge mclk_i);
		#1;
		q = rdata_i;
	endtask
	task automatic idle();
		req_o = '0;
		@(posedge mclk_i);
		#1;
	endtask
endmodule
`default_nettype wire

/* sim/tb_timer16_byte_access.sv */
`default_nettype none
module tb_timer16_byte_access;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  mclk_i = 1'b0, rst_n_i = 1'b0, ext_clk_i = 1'b0;
	logic                  capture_i = 1'b0, clear_i = 1'b0, down_i = 1'b0;
	timer16_pkg::cpu_req_t req;
	logic [7:0]            rdata, d;
	logic [15:0]           cnt, cmpa, cmpb, cap, v, w, r;
	logic [7:0]            ctlb;
	int                    err_count = 0, comparisons = 0, seed = 33433;
	timer16_byte_access dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
		.ext_clk_i(ext_clk_i), .capture_i(capture_i), .clear_i(clear_i), .down_i(down_i),
		.counter_value_o(cnt), .compare_a_o(cmpa), .compare_b_o(cmpb),
		.capture_value_o(cap), .timer_control_b_o(ctlb));
	timer16_cpu_model cpu (.mclk_i(mclk_i), .req_o(req), .rdata_i(rdata));
	initial begin
		forever #2 mclk_i = ~mclk_i;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr16(input logic [3:0] lo, input logic [15:0] x);
		cpu.xfer(1'b0, lo + 4'h1, x[15:8], d);
		cpu.xfer(1'b0, lo, x[7:0], d);
		cpu.idle();
	endtask
	task automatic rd16(input logic [3:0] lo, output logic [15:0] x);
		cpu.xfer(1'b1, lo, 8'h00, d);
		x[7:0] = d;
		cpu.xfer(1'b1, lo + 4'h1, 8'h00, d);
		x[15:8] = d;
		cpu.idle();
	endtask
	task automatic ctl(input logic [7:0] c, input int n);
		cpu.xfer(1'b0, 4'h8, c, d);
		repeat (n) cpu.idle();
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watchdog: every wait below is fixed, so this only trips on a hang
	initial begin
		#100000;
		err_count++;
		test_done();
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		#1;
		rst_n_i = 1'b1;
		cpu.xfer(1'b0, 4'h0, 8'h5a, d);
		cpu.idle();
		chk(cnt, 16'h005a);
		for (int i = 0; i < 24; i++) begin
			v = 16'($random(seed));
			w = 16'($random(seed));
			wr16(4'h0, v);
			wr16(4'h2, w);
			wr16(4'h6, v ^ w);
			chk(cnt, v);
			chk(cmpa, w);
			chk(cap, v ^ w);
			rd16(4'h0, r);
			chk(r, v);
			rd16(4'h2, r);
			chk(r, w);
			rd16(4'h6, r);
			chk(r, v ^ w);
		end
		// Interloper on another register spoils the pending high byte
		cpu.xfer(1'b1, 4'h0, 8'h00, d);
		cpu.xfer(1'b0, 4'h5, 8'hc3, d);
		cpu.xfer(1'b1, 4'h3, 8'h00, d);
		chk({8'h00, d}, {8'h00, w[15:8]});
		cpu.xfer(1'b1, 4'h1, 8'h00, d);
		chk({8'h00, d}, 16'h00c3);
		cpu.xfer(1'b0, 4'h0, 8'h11, d);
		cpu.xfer(1'b0, 4'h4, 8'h22, d);
		cpu.idle();
		chk(cnt, 16'hc311);
		chk(cmpb, 16'hc322);
		ctl(8'h01, 4);
		v = cnt;
		repeat (5) cpu.idle();
		chk(cnt, v + 16'h0005);
		down_i = 1'b1;
		repeat (4) cpu.idle();
		v = cnt;
		repeat (5) cpu.idle();
		chk(cnt, v - 16'h0005);
		clear_i = 1'b1;
		repeat (4) cpu.idle();
		chk(cnt, 16'h0000);
		wr16(4'h0, 16'hbeef);
		clear_i = 1'b0;
		ctl(8'h00, 3);
		v = cnt;
		repeat (6) cpu.idle();
		chk(cnt, v);
		chk({8'h00, ctlb}, 16'h0000);
		cpu.xfer(1'b1, 4'h8, 8'h00, d);
		chk({8'h00, d}, 16'h0000);
		// A capture strobe snapshots the stopped counter
		capture_i = 1'b1;
		cpu.idle();
		capture_i = 1'b0;
		chk(cap, v);
		// A low-byte write beats a capture strobe in the same cycle
		capture_i = 1'b1;
		cpu.xfer(1'b0, 4'h6, 8'h77, d);
		capture_i = 1'b0;
		cpu.idle();
		chk(cap, 16'hbe77);
		// Divide-by-8 tap: any 16 consecutive cycles hold exactly two ticks
		down_i = 1'b0;
		ctl(8'h02, 0);
		chk({8'h00, ctlb}, 16'h0002);
		v = cnt;
		repeat (16) cpu.idle();
		chk(cnt, v + 16'h0002);
		// External rising edges, one count per pulse
		ctl(8'h07, 1);
		v = cnt;
		repeat (3) begin
			ext_clk_i = 1'b1;
			cpu.idle();
			ext_clk_i = 1'b0;
			cpu.idle();
		end
		chk(cnt, v + 16'h0003);
		for (int m = 0; m < 16; m++) begin
			ctl(8'(m), 1);
			repeat (40) begin
				{ext_clk_i, capture_i, clear_i, down_i} = 4'($random(seed));
				cpu.idle();
			end
		end
		test_done();
	end
endmodule
`default_nettype wire
